// *** ivms_defines.vh ***
// Purpose: constants for the internal vco mode setup block
// Assumes: 8-bit registers reached over a plain strobe port
// Notes:   offsets are byte addresses of the control space
`ifndef IVMS_DEFINES_VH
`define IVMS_DEFINES_VH

`define IVMS_AW          10
`define IVMS_DW          8
`define IVMS_NREG        17
`define IVMS_IW          5

`define IVMS_A_PLL_FIRST 10'h010
`define IVMS_A_PLL_LAST  10'h01e
`define IVMS_A_STATUS    10'h01f
`define IVMS_A_NVM       10'h0b3
`define IVMS_A_VDIV      10'h1e0
`define IVMS_A_SRC       10'h1e1
`define IVMS_A_XFER      10'h232

`define IVMS_I_PWR       5'h00
`define IVMS_I_CAL       5'h08
`define IVMS_I_REFEN     5'h0c
`define IVMS_I_VDIV      5'h0f
`define IVMS_I_SRC       5'h10
`define IVMS_I_LAST      5'h10
`define IVMS_I_NONE      5'h11

`define IVMS_B_PFD_POL   7
`define IVMS_B_CAL       0
`define IVMS_B_SRC_VCO   1
`define IVMS_B_BYPASS    0
`define IVMS_B_XFER      0
`define IVMS_B_STORE     0

`define IVMS_PWR_ON      2'h0
`define IVMS_RST_PWR     8'h01
`define IVMS_RST_OTHER   8'h00
`define IVMS_MASK_VDIV   8'h07
`define IVMS_MASK_SRC    8'h03
`define IVMS_MASK_ALL    8'hff

`define IVMS_CLK_PERIOD_PS 5000
`define IVMS_CAL_TIME_NS   4000

`endif

// *** ivms_core.v ***
// Purpose: buffered control registers, vco calibration and config save/restore
// Assumes: nonvolatile store answers a read one cycle after its read strobe
// Notes:   reads return the buffered values, not the active ones
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ivms_defines.vh"

module ivms_core #(
  parameter CAL_TIME_NS = `IVMS_CAL_TIME_NS,
  parameter CAL_CYCLES  = (CAL_TIME_NS * 1000 + `IVMS_CLK_PERIOD_PS - 1) / `IVMS_CLK_PERIOD_PS
) (
  input  wire                      clk,          // 200 MHz clock
  input  wire                      rst_b,        // async reset, active low
  input  wire [`IVMS_AW-1:0]       addr,         // register address
  input  wire [`IVMS_DW-1:0]       wdata,        // write data
  input  wire                      we,           // write strobe
  input  wire                      re,           // read strobe
  output reg  [`IVMS_DW-1:0]       rdata,        // read data, cycle after re
  input  wire                      nvm_valid_i,  // store holds a saved config
  input  wire [`IVMS_DW-1:0]       nvm_rdata_i,  // store read data
  output reg                       nvm_re_o,     // store read strobe
  output reg                       nvm_we_o,     // store write strobe
  output reg  [`IVMS_IW-1:0]       nvm_addr_o,   // store entry index
  output reg  [`IVMS_DW-1:0]       nvm_wdata_o,  // store write data
  output wire [1:0]                pll_pwr_o,    // active pll power code
  output wire                      pfd_neg_o,    // detector polarity negative
  output wire [2:0]                ref_en_o,     // enabled reference inputs
  output wire                      clk_src_vco_o,// internal vco is the source
  output wire                      div_bypass_o, // vco divider bypassed
  output wire [2:0]                vco_div_o,    // vco divider ratio code
  output wire [15*`IVMS_DW-1:0]    pll_cfg_o,    // active pll range, entry 0 low
  output reg                       cal_busy_o,   // calibration running
  output reg                       cal_done_o    // calibration finished
);

  localparam [2:0] S_IDLE  = 3'b001;
  localparam [2:0] S_BOOT  = 3'b010;
  localparam [2:0] S_STORE = 3'b100;
  localparam integer CAL_LAST_I = CAL_CYCLES - 1;
  localparam [15:0]  CAL_LAST   = CAL_LAST_I[15:0];

  function [`IVMS_IW-1:0] reg_idx;
    input [`IVMS_AW-1:0] a;
    reg   [`IVMS_AW-1:0] off;
    begin
      off = a - `IVMS_A_PLL_FIRST;
      if (a >= `IVMS_A_PLL_FIRST && a <= `IVMS_A_PLL_LAST)
        reg_idx = off[`IVMS_IW-1:0];
      else if (a == `IVMS_A_VDIV)
        reg_idx = `IVMS_I_VDIV;
      else if (a == `IVMS_A_SRC)
        reg_idx = `IVMS_I_SRC;
      else
        reg_idx = `IVMS_I_NONE;
    end
  endfunction

  function [`IVMS_DW-1:0] wr_mask;
    input [`IVMS_IW-1:0] i;
    begin
      if (i == `IVMS_I_VDIV)
        wr_mask = `IVMS_MASK_VDIV;
      else if (i == `IVMS_I_SRC)
        wr_mask = `IVMS_MASK_SRC;
      else
        wr_mask = `IVMS_MASK_ALL;
    end
  endfunction

  reg  [`IVMS_DW-1:0] buf_q [0:`IVMS_NREG-1];
  reg  [`IVMS_DW-1:0] act_q [0:`IVMS_NREG-1];
  reg  [2:0]          st_q;
  reg  [`IVMS_IW-1:0] ptr_q;
  reg                 cap_q;
  reg  [`IVMS_IW-1:0] cap_idx_q;
  reg                 boot_req_q;
  reg                 apply_q;
  reg  [15:0]         cal_cnt_q;

  wire [`IVMS_IW-1:0] acc_idx;
  wire                busy;
  wire                host_wr;
  wire                xfer;
  wire                store_req;
  wire                cal_go;
  wire                cal_clr;
  wire                cal_end;
  wire [`IVMS_DW-1:0] status;

  assign acc_idx   = reg_idx(addr);
  // boot check, save/restore own the buffer; host writes and transfer/save strobes are dropped meanwhile, reads still served
  assign busy      = ~st_q[0] | boot_req_q | nvm_re_o | cap_q | apply_q;
  assign host_wr   = we & ~busy & (acc_idx != `IVMS_I_NONE);
  assign xfer      = we & ~busy & (addr == `IVMS_A_XFER) & wdata[`IVMS_B_XFER];
  assign store_req = we & ~busy & (addr == `IVMS_A_NVM) & wdata[`IVMS_B_STORE];

  genvar g;
  generate
    for (g = 0; g < `IVMS_NREG; g = g + 1)
    begin : g_reg
      localparam [`IVMS_DW-1:0] RV = (g == 0) ? `IVMS_RST_PWR : `IVMS_RST_OTHER;
      localparam [`IVMS_IW-1:0] GI = g;
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          buf_q[g] <= RV;
          act_q[g] <= RV;
        end
        else
        begin
          if (cap_q && cap_idx_q == GI)
            buf_q[g] <= nvm_rdata_i & wr_mask(GI);
          else if (host_wr && acc_idx == GI)
            buf_q[g] <= wdata & wr_mask(GI);
          if (apply_q)
            act_q[g] <= buf_q[g];
        end
      end
      if (g < 15)
      begin : g_cfg
        assign pll_cfg_o[g*`IVMS_DW +: `IVMS_DW] = act_q[g];
      end
    end
  endgenerate

  assign pll_pwr_o     = act_q[`IVMS_I_PWR][1:0];
  assign pfd_neg_o     = act_q[`IVMS_I_PWR][`IVMS_B_PFD_POL];
  assign ref_en_o      = act_q[`IVMS_I_REFEN][2:0];
  assign clk_src_vco_o = act_q[`IVMS_I_SRC][`IVMS_B_SRC_VCO];
  assign div_bypass_o  = act_q[`IVMS_I_SRC][`IVMS_B_BYPASS];
  assign vco_div_o     = act_q[`IVMS_I_VDIV][2:0];

  // apply follows a transfer strobe or the last restored entry
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      apply_q <= 1'b0;
    else
      apply_q <= xfer | (cap_q & (cap_idx_q == `IVMS_I_LAST));
  end

  // start needs a 0 to 1 edge of the bit, so a stale set bit cannot re-run it
  assign cal_go  = apply_q & buf_q[`IVMS_I_CAL][`IVMS_B_CAL]
                 & ~act_q[`IVMS_I_CAL][`IVMS_B_CAL]
                 & buf_q[`IVMS_I_SRC][`IVMS_B_SRC_VCO]
                 & (buf_q[`IVMS_I_PWR][1:0] == `IVMS_PWR_ON);
  assign cal_clr = apply_q & ~buf_q[`IVMS_I_CAL][`IVMS_B_CAL];
  assign cal_end = cal_busy_o & (cal_cnt_q == 16'h0000);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cal_busy_o <= 1'b0;
      cal_done_o <= 1'b0;
      cal_cnt_q  <= 16'h0000;
    end
    else
    begin
      if (cal_go)
      begin
        cal_busy_o <= 1'b1;
        cal_cnt_q  <= CAL_LAST;
      end
      else if (cal_clr || cal_end)
        cal_busy_o <= 1'b0;
      else if (cal_busy_o)
        cal_cnt_q <= cal_cnt_q - 16'h0001;
      // completion beats a clear landing in the same cycle
      if (cal_end)
        cal_done_o <= 1'b1;
      else if (cal_clr || cal_go)
        cal_done_o <= 1'b0;
    end
  end

  // restore after reset, save on request
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q        <= S_IDLE;
      ptr_q       <= 5'h00;
      boot_req_q  <= 1'b1;
      nvm_re_o    <= 1'b0;
      nvm_we_o    <= 1'b0;
      nvm_addr_o  <= 5'h00;
      nvm_wdata_o <= 8'h00;
      cap_q       <= 1'b0;
      cap_idx_q   <= 5'h00;
    end
    else
    begin
      nvm_re_o  <= 1'b0;
      nvm_we_o  <= 1'b0;
      cap_q     <= nvm_re_o;
      cap_idx_q <= nvm_addr_o;
      case (st_q)
        S_IDLE:
        begin
          ptr_q <= 5'h00;
          if (boot_req_q)
          begin
            boot_req_q <= 1'b0;
            if (nvm_valid_i)
              st_q <= S_BOOT;
          end
          else if (store_req)
            st_q <= S_STORE;
        end
        S_BOOT:
        begin
          nvm_re_o   <= 1'b1;
          nvm_addr_o <= ptr_q;
          ptr_q      <= ptr_q + 5'h01;
          if (ptr_q == `IVMS_I_LAST)
            st_q <= S_IDLE;
        end
        S_STORE:
        begin
          nvm_we_o    <= 1'b1;
          nvm_addr_o  <= ptr_q;
          nvm_wdata_o <= buf_q[ptr_q];
          ptr_q       <= ptr_q + 5'h01;
          if (ptr_q == `IVMS_I_LAST)
            st_q <= S_IDLE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  assign status = {4'h0, (act_q[`IVMS_I_PWR][1:0] == `IVMS_PWR_ON), busy,
                   cal_done_o, cal_busy_o};

  // unmapped addresses and the transfer strobe read as zero
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (!re)
      rdata <= 8'h00;
    else if (acc_idx != `IVMS_I_NONE)
      rdata <= buf_q[acc_idx];
    else if (addr == `IVMS_A_STATUS)
      rdata <= status;
    else if (addr == `IVMS_A_NVM)
      rdata <= {7'h00, busy};
    else
      rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// *** ivms_core_sva.sv ***
// Purpose: port-level checks of the vco mode setup core
// Assumes: single clock, reset active low
// Notes:   restore apply is allowed up to six cycles after the last store read
`timescale 1ns/1ps
`default_nettype none
`include "ivms_defines.vh"
module ivms_core_chk #(
  parameter int CAL_CYCLES = 800
) (
  input wire logic                clk,           // clock
  input wire logic                rst_b,         // reset, active low
  input wire logic [`IVMS_AW-1:0] addr,          // address
  input wire logic [`IVMS_DW-1:0] wdata,         // write data
  input wire logic                we,            // write strobe
  input wire logic                nvm_re_o,      // store read
  input wire logic                nvm_we_o,      // store write
  input wire logic [`IVMS_IW-1:0] nvm_addr_o,    // store index
  input wire logic [1:0]          pll_pwr_o,     // pll power
  input wire logic [2:0]          ref_en_o,      // references
  input wire logic                clk_src_vco_o, // vco source
  input wire logic [2:0]          vco_div_o,     // divider code
  input wire logic                cal_busy_o,    // cal running
  input wire logic                cal_done_o     // cal finished
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [2:0]  since_rd_q;
  logic [4:0]  we_run_q;
  logic [4:0]  re_run_q;
  logic [15:0] busy_run_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      since_rd_q <= 3'h7;
      we_run_q   <= 5'h00;
      re_run_q   <= 5'h00;
      busy_run_q <= 16'h0000;
    end
    else
    begin
      // saturate so the restore window ends
      since_rd_q <= nvm_re_o ? 3'h0 : (since_rd_q == 3'h7 ? 3'h7 : since_rd_q + 3'h1);
      we_run_q   <= nvm_we_o ? we_run_q + 5'h01 : 5'h00;
      re_run_q   <= nvm_re_o ? re_run_q + 5'h01 : 5'h00;
      busy_run_q <= cal_busy_o ? busy_run_q + 16'h0001 : 16'h0000;
    end
  end
  a_write_buffered: assert property (($changed(ref_en_o) || $changed(vco_div_o))
    |-> $past(we && addr == `IVMS_A_XFER && wdata[0], 2) || since_rd_q < 3'h6)
    else $error("active config moved without transfer");
  a_save_trigger: assert property (we && addr == `IVMS_A_NVM && wdata[0] && !nvm_we_o
    && !nvm_re_o && since_rd_q > 3'h5 && !$past(we && addr == `IVMS_A_XFER) |-> ##2 nvm_we_o)
    else $error("save did not start");
  a_save_first: assert property ($rose(nvm_we_o) |-> nvm_addr_o == 5'h00)
    else $error("save not from entry zero");
  a_save_order: assert property (nvm_we_o && $past(nvm_we_o)
    |-> nvm_addr_o == $past(nvm_addr_o) + 5'h01) else $error("save index not ascending");
  a_save_len: assert property ($fell(nvm_we_o) |-> we_run_q == 5'h11)
    else $error("save length wrong");
  a_restore_len: assert property ($fell(nvm_re_o) |-> re_run_q == 5'h11)
    else $error("restore length wrong");
  a_cal_start: assert property ($rose(cal_busy_o) |-> clk_src_vco_o && pll_pwr_o == 2'h0
    && ($past(we && addr == `IVMS_A_XFER && wdata[0], 2) || since_rd_q < 3'h6))
    else $error("calibration started without cause");
  a_cal_len: assert property ($fell(cal_busy_o) && cal_done_o
    |-> busy_run_q == 16'(CAL_CYCLES)) else $error("calibration length wrong");
  a_done_rise: assert property ($rose(cal_done_o) |-> $past(cal_busy_o) && !cal_busy_o)
    else $error("done without calibration");
endmodule
bind ivms_core ivms_core_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .we(we), .nvm_re_o(nvm_re_o), .nvm_we_o(nvm_we_o),
  .nvm_addr_o(nvm_addr_o), .pll_pwr_o(pll_pwr_o), .ref_en_o(ref_en_o),
  .clk_src_vco_o(clk_src_vco_o), .vco_div_o(vco_div_o), .cal_busy_o(cal_busy_o),
  .cal_done_o(cal_done_o));
`default_nettype wire

// *** ivms_nvm_model.sv ***
// Purpose: behavioural nonvolatile store beside the core
// Assumes: read data one cycle after the read strobe
// Notes:   data outside a read toggles so stale values never match
`timescale 1ns/1ps
`default_nettype none
module ivms_nvm_model (
  input  wire logic       clk,   // clock
  input  wire logic       re,    // read strobe
  input  wire logic       we,    // write strobe
  input  wire logic [4:0] addr,  // entry index
  input  wire logic [7:0] wdata, // write data
  output var  logic [7:0] rdata, // read data
  output var  logic       valid  // holds a saved config
);
  logic [7:0] mem_q [0:16];
  initial valid = 1'b0;
  initial rdata = 8'h5a;
  always @(posedge clk)
  begin
    if (we)
    begin
      mem_q[addr] <= wdata;
      valid <= 1'b1;
    end
    rdata <= re ? mem_q[addr] : ~rdata;
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: directed register-level test of the vco mode setup core
// Assumes: calibration shortened to four cycles
// Notes:   second reset exercises restore from the store
`timescale 1ns/1ps
`default_nettype none
`include "ivms_defines.vh"
module testbench;
  localparam int CALN = 4;
  logic clk = 1'b0, rst_b = 1'b0, we = 1'b0, re = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00, rdata, nv_rd, nv_wd;
  logic nv_ok, nv_re, nv_we, pfd, src, byp, busy, done;
  logic [4:0] nv_a;
  logic [1:0] pwr;
  logic [2:0] ref_en, vdiv;
  logic [119:0] cfg;
  int n_mismatch = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  ivms_core #(.CAL_CYCLES(CALN)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .nvm_valid_i(nv_ok),
    .nvm_rdata_i(nv_rd), .nvm_re_o(nv_re), .nvm_we_o(nv_we), .nvm_addr_o(nv_a),
    .nvm_wdata_o(nv_wd), .pll_pwr_o(pwr), .pfd_neg_o(pfd), .ref_en_o(ref_en),
    .clk_src_vco_o(src), .div_bypass_o(byp), .vco_div_o(vdiv), .pll_cfg_o(cfg),
    .cal_busy_o(busy), .cal_done_o(done));
  ivms_nvm_model u_nvm (.clk(clk), .re(nv_re), .we(nv_we), .addr(nv_a), .wdata(nv_wd),
    .rdata(nv_rd), .valid(nv_ok));
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #5000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    chk("src", {7'h0, src}, 8'h00);
    wr(10'h010, 8'h80);
    wr(10'h01c, 8'h05);
    wr(10'h1e0, 8'hff);
    wr(10'h1e1, 8'h02);
    wr(10'h018, 8'h01);
    cyc(2);
    chk("ref_en", {5'h0, ref_en}, 8'h00);
    rd(10'h1e0, 8'h07);
    rd(10'h3ff, 8'h00);
    wr(`IVMS_A_XFER, 8'h01);
    cyc(2);
    chk("src", {7'h0, src}, 8'h01);
    chk("pfd", {7'h0, pfd}, 8'h01);
    chk("cfg_cal", cfg[71:64], 8'h01);
    chk("byp", {7'h0, byp}, 8'h00);
    chk("vdiv", {5'h0, vdiv}, 8'h07);
    chk("ref_en", {5'h0, ref_en}, 8'h05);
    chk("cfg0", cfg[7:0], 8'h80);
    chk("busy", {7'h0, busy}, 8'h01);
    cyc(CALN);
    chk("done", {6'h0, busy, done}, 8'h01);
    rd(10'h01f, 8'h0a);
    wr(`IVMS_A_XFER, 8'h01);
    cyc(2);
    chk("busy", {7'h0, busy}, 8'h00);
    chk("done_kept", {7'h0, done}, 8'h01);
    wr(10'h018, 8'h00);
    wr(`IVMS_A_XFER, 8'h01);
    cyc(2);
    chk("done", {7'h0, done}, 8'h00);
    wr(10'h018, 8'h01);
    wr(`IVMS_A_XFER, 8'h01);
    cyc(2);
    chk("busy", {7'h0, busy}, 8'h01);
    wr(10'h1e1, 8'h01);
    wr(`IVMS_A_XFER, 8'h01);
    cyc(2);
    chk("src_byp", {6'h0, src, byp}, 8'h01);
    wr(`IVMS_A_NVM, 8'h01);
    rd(`IVMS_A_NVM, 8'h01);
    // refused while saving, so the restore below must still see 05
    wr(10'h01c, 8'h02);
    cyc(25);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    cyc(30);
    chk("pwr", {6'h0, pwr}, 8'h00);
    chk("vdiv_byp", {4'h0, vdiv, byp}, 8'h0f);
    chk("ref_en", {5'h0, ref_en}, 8'h05);
    give_verdict();
  end
endmodule
`default_nettype wire
